// *** core/tscp_cfg.svh ***
// Constants for the three-stage pipeline control: fields, codes, addresses and counts
`ifndef TSCP_CFG_SVH
`define TSCP_CFG_SVH

// Instruction fields (32-bit word)
`define TSCP_F_OP       31:28
`define TSCP_F_RD       27:24
`define TSCP_F_RS1      23:20
`define TSCP_F_RS2      19:16
`define TSCP_F_IMM16    15:0
`define TSCP_F_SIZE     15:14
`define TSCP_F_SIGN     13
`define TSCP_F_OFS      12:0
`define TSCP_F_SRBITS   4:0

// Operation codes
`define TSCP_OP_NOP     4'h0
`define TSCP_OP_ADD     4'h1
`define TSCP_OP_SUB     4'h2
`define TSCP_OP_AND     4'h3
`define TSCP_OP_OR      4'h4
`define TSCP_OP_XOR     4'h5
`define TSCP_OP_ADDI    4'h6
`define TSCP_OP_MUL     4'h7
`define TSCP_OP_LOAD    4'h8
`define TSCP_OP_STORE   4'h9
`define TSCP_OP_JUMP    4'ha
`define TSCP_OP_SRSET   4'hb
`define TSCP_OP_SRCLR   4'hc
`define TSCP_OP_RETD    4'hd

// Transfer sizes
`define TSCP_SZ_BYTE    2'h0
`define TSCP_SZ_HALF    2'h1
`define TSCP_SZ_WORD    2'h2
`define TSCP_SZ_DWORD   2'h3

// Addresses, register indices and counts
`define TSCP_RESET_ADDR   32'h0000_0000
`define TSCP_DEBUG_VECTOR 32'h0000_0100
`define TSCP_INST_STEP    32'h0000_0004
`define TSCP_WORD_STEP    32'h0000_0004
`define TSCP_PC_INDEX     4'hf
`define TSCP_LR_INDEX     4'he
`define TSCP_SP_INDEX     4'hd
`define TSCP_SR_DMASK_BIT 4
`define TSCP_INT_LEVELS   4
`define TSCP_MUL_CYCLES   3

`endif

// *** core/tscp_pkg.sv ***
// Types shared by the pipeline control, its memory model and its bench
package tscp_pkg;

    typedef enum logic [1:0] {TSCP_MEM_IDLE, TSCP_MEM_FIRST, TSCP_MEM_SECOND} tscp_mem_phase_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0]  be;
    } tscp_dmem_req_t;

    typedef struct packed {
        logic [31:0]     pcF;
        logic            imemReq;
        logic            decV;
        logic [31:0]     decInstr;
        logic [31:0]     decPc;
        logic            exV;
        logic            exFirst;
        logic [31:0]     exInstr;
        logic [31:0]     exPc;
        logic [3:0]      mulCnt;
        tscp_mem_phase_t memPh;
        tscp_dmem_req_t  dmem;
        logic            debugState;
        logic [3:0]      intMask;
        logic            debugMask;
        logic [31:0]     retAddr;
        logic [3:0]      savedIntMask;
        logic            savedDebugMask;
        logic            retireValid;
        logic [31:0]     retirePc;
        logic [2:0]      dbgSync;
        logic            dbgReq;
    } tscp_state_t;

endpackage

// *** core/tscp_regfile.sv ***
// Register file: write-first, registered read ports, program counter entry
`timescale 1ns/1ps
`default_nettype none
module tscp_regfile #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 32,
    parameter int NRD   = 3,
    parameter int AW    = 4,
    parameter logic [AW-1:0] PC_ENTRY = 4'hf
) (
    // Clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     reset,
    // Read ports, sampled when rdEn is high
    input  wire logic                     rdEn,
    input  wire logic [NRD-1:0][AW-1:0]   rdAddr,
    output logic      [NRD-1:0][WIDTH-1:0] rdData,
    // Result write port
    input  wire logic                     wrEn,
    input  wire logic [AW-1:0]            wrAddr,
    input  wire logic [WIDTH-1:0]         wrData,
    // Program counter write port
    input  wire logic                     pcWrEn,
    input  wire logic [WIDTH-1:0]         pcWrData
);
    typedef struct packed {
        logic [NRD-1:0][WIDTH-1:0]   rd;
        logic [DEPTH-1:0][WIDTH-1:0] mem;
    } tscp_rf_state_t;

    tscp_rf_state_t s;
    tscp_rf_state_t next_s;

    ////////////////////////////////////////////////////////////////////////////
    // Writes land first so a read in the same cycle sees them; this is what
    // lets the pipeline run with no bypass network at all
    always_comb begin
        next_s = s;
        if (pcWrEn) begin
            next_s.mem[PC_ENTRY] = pcWrData;
        end
        if (wrEn) begin
            next_s.mem[wrAddr] = wrData;
        end
        if (rdEn) begin
            for (int i = 0; i < NRD; i++) begin
                next_s.rd[i] = next_s.mem[rdAddr[i]];
            end
        end
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rdData = s.rd;

endmodule // tscp_regfile
`default_nettype wire

// *** core/tscp_pipeline.sv ***
// Three-stage in-order pipeline control with register file and debug state
//
// Behaviour
// - Instructions pass fetch, decode and execute, three stages only.
// - Execute routes arithmetic, product and load/store instructions to their sections; jump, return and status ops are handled apart.
// - Issue and retire strictly in program order, never out of order.
// - Multi-cycle work holds decode and execute, stalling younger instructions.
// - No operand forwarding paths; write-first register file removes hazards.
// - One instruction completes per cycle except multi-cycle operations.
// - Register file holds fifteen general-purpose 32-bit registers.
// - Stack pointer, program counter, link register live inside the register file.
// - Byte, half, word, double transfers; sub-word loads sign or zero extended.
// - Entering debug state sets every interrupt level mask bit.
// - In debug state software clears mask bits per interrupt level.
// - Debug state is left only by the return-from-debug instruction.
// - Debug entry refused while the debug-entry mask bit is set.
`include "tscp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tscp_pipeline #(
    parameter int MUL_CYCLES = `TSCP_MUL_CYCLES
) (
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   reset,
    // Instruction memory, combinational answer
    output logic                        imemReq,
    output logic [31:0]                 imemAddr,
    input  wire logic                   imemValid,
    input  wire logic [31:0]            imemData,
    // Data memory, request held until dmemValid
    output tscp_pkg::tscp_dmem_req_t    dmemOut,
    input  wire logic                   dmemValid,
    input  wire logic [31:0]            dmemRdata,
    // Debug request pin
    input  wire logic                   debugReqPin,
    // Status
    output logic                        debugState,
    output logic [3:0]                  intMask,
    output logic                        debugMask,
    output logic                        retireValid,
    output logic [31:0]                 retirePc
);
    import tscp_pkg::*;

    tscp_state_t s;
    tscp_state_t next_s;

    logic [2:0][31:0] rdData;
    logic             rfWrEn, exDone, redirect, adv, takeDbg;
    logic [3:0]       rfWrAddr, exOp;
    logic [31:0]      rfWrData, target, opA, opB, opC, ea, aluRes;
    logic [63:0]      product;

    ////////////////////////////////////////////////////////////////////////////
    // Sub-word load extraction from the addressed lane
    function automatic logic [31:0] load_extend(input logic [31:0] d, input logic [1:0] a,
                                                input logic [1:0] sz, input logic sgn);
        logic [7:0]  b;
        logic [15:0] h;
        b = d[8*a +: 8];
        h = d[16*a[1] +: 16];
        case (sz)
            `TSCP_SZ_BYTE: load_extend = {{24{sgn & b[7]}}, b};
            `TSCP_SZ_HALF: load_extend = {{16{sgn & h[15]}}, h};
            default:       load_extend = d;
        endcase
    endfunction

    // Byte enables for a store of the given size
    function automatic logic [3:0] lane_enable(input logic [1:0] a, input logic [1:0] sz);
        case (sz)
            `TSCP_SZ_BYTE: lane_enable = 4'h1 << a;
            `TSCP_SZ_HALF: lane_enable = a[1] ? 4'hc : 4'h3;
            default:       lane_enable = 4'hf;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register file; operands are captured only when decode hands over, so
    // they stay put while a multi-cycle instruction sits in execute
    tscp_regfile #(
        .DEPTH    (16),
        .WIDTH    (32),
        .NRD      (3),
        .AW       (4),
        .PC_ENTRY (`TSCP_PC_INDEX)
    ) u_regfile (
        .core_clk (core_clk),
        .reset    (reset),
        .rdEn     (adv),
        .rdAddr   ({s.decInstr[`TSCP_F_RD], s.decInstr[`TSCP_F_RS2], s.decInstr[`TSCP_F_RS1]}),
        .rdData   (rdData),
        .wrEn     (rfWrEn),
        .wrAddr   (rfWrAddr),
        .wrData   (rfWrData),
        .pcWrEn   (1'b1),
        .pcWrData (s.pcF)
    );

    assign opA = rdData[0];
    assign opB = rdData[1];
    assign opC = rdData[2];
    assign exOp = s.exInstr[`TSCP_F_OP];
    assign ea = opA + {{19{s.exInstr[12]}}, s.exInstr[`TSCP_F_OFS]};
    assign product = opA * opB;

    // Arithmetic/logic section
    always_comb begin
        case (exOp)
            `TSCP_OP_ADD:  aluRes = opA + opB;
            `TSCP_OP_SUB:  aluRes = opA - opB;
            `TSCP_OP_AND:  aluRes = opA & opB;
            `TSCP_OP_OR:   aluRes = opA | opB;
            `TSCP_OP_XOR:  aluRes = opA ^ opB;
            `TSCP_OP_ADDI: aluRes = opA + {{16{s.exInstr[15]}}, s.exInstr[`TSCP_F_IMM16]};
            default:       aluRes = s.exPc + `TSCP_INST_STEP;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Execute stage: routing, completion and write-back
    always_comb begin
        rfWrEn   = 1'b0;
        rfWrAddr = s.exInstr[`TSCP_F_RD];
        rfWrData = aluRes;
        exDone   = 1'b0;
        redirect = 1'b0;
        target   = aluRes;
        if (s.exV) begin
            case (exOp)
                `TSCP_OP_ADD, `TSCP_OP_SUB, `TSCP_OP_AND, `TSCP_OP_OR, `TSCP_OP_XOR,
                `TSCP_OP_ADDI: begin
                    exDone = 1'b1;
                    rfWrEn = 1'b1;
                end
                `TSCP_OP_MUL: begin
                    exDone   = (s.mulCnt == 4'h0);
                    rfWrEn   = exDone;
                    rfWrData = product[31:0];
                end
                `TSCP_OP_LOAD, `TSCP_OP_STORE: begin
                    if (s.memPh != TSCP_MEM_IDLE && dmemValid) begin
                        rfWrEn   = (exOp == `TSCP_OP_LOAD);
                        rfWrData = load_extend(dmemRdata, s.dmem.addr[1:0],
                                               s.exInstr[`TSCP_F_SIZE],
                                               s.exInstr[`TSCP_F_SIGN]);
                        if (s.memPh == TSCP_MEM_SECOND) rfWrAddr = s.exInstr[`TSCP_F_RD] + 4'h1;
                        exDone = (s.memPh == TSCP_MEM_SECOND) ||
                                 (s.exInstr[`TSCP_F_SIZE] != `TSCP_SZ_DWORD);
                    end
                end
                `TSCP_OP_JUMP: begin
                    exDone   = 1'b1;
                    redirect = 1'b1;
                    rfWrEn   = 1'b1;
                    rfWrAddr = `TSCP_LR_INDEX;
                    rfWrData = s.exPc + `TSCP_INST_STEP;
                    target   = opA + {{16{s.exInstr[15]}}, s.exInstr[`TSCP_F_IMM16]};
                end
                `TSCP_OP_RETD: begin
                    exDone   = 1'b1;
                    redirect = s.debugState;
                    target   = s.retAddr;
                end
                default: exDone = 1'b1;
            endcase
        end
    end

    // Decode hands over only when execute is free or finishing this cycle
    assign adv     = s.decV && (!s.exV || exDone) && !redirect;
    assign takeDbg = s.dbgReq && !s.debugMask && !s.debugState && adv;

    ////////////////////////////////////////////////////////////////////////////
    // Next state of every stage and of the status bits
    always_comb begin
        next_s = s;
        next_s.imemReq     = 1'b1; // Fetch request is registered, so it rises one cycle after reset is released
        next_s.retireValid = exDone;
        next_s.retirePc    = s.exPc;
        next_s.exFirst     = 1'b0;
        // Pin synchroniser; the level changes only once stages two and three agree
        next_s.dbgSync = {s.dbgSync[1:0], debugReqPin};
        if (s.dbgSync[2] == s.dbgSync[1]) begin
            next_s.dbgReq = s.dbgSync[2];
        end
        // Product section: counts down its fixed latency
        if (s.exV && exOp == `TSCP_OP_MUL && s.mulCnt != 4'h0) begin
            next_s.mulCnt = s.mulCnt - 4'h1;
        end
        // Load/store section: one or two word accesses
        if (s.exV && (exOp == `TSCP_OP_LOAD || exOp == `TSCP_OP_STORE)) begin
            if (s.memPh == TSCP_MEM_IDLE) begin
                next_s.memPh      = TSCP_MEM_FIRST;
                next_s.dmem.req   = 1'b1;
                next_s.dmem.we    = (exOp == `TSCP_OP_STORE);
                next_s.dmem.addr  = ea;
                next_s.dmem.be    = lane_enable(ea[1:0], s.exInstr[`TSCP_F_SIZE]);
                next_s.dmem.wdata = s.exInstr[`TSCP_F_SIZE] == `TSCP_SZ_BYTE ? {4{opB[7:0]}} :
                                    s.exInstr[`TSCP_F_SIZE] == `TSCP_SZ_HALF ? {2{opB[15:0]}} :
                                    opB;
            end else if (dmemValid && !exDone) begin
                next_s.memPh      = TSCP_MEM_SECOND;
                next_s.dmem.addr  = s.dmem.addr + `TSCP_WORD_STEP;
                next_s.dmem.wdata = opC;
            end else if (exDone) begin
                next_s.memPh    = TSCP_MEM_IDLE;
                next_s.dmem.req = 1'b0;
                next_s.dmem.we  = 1'b0;
            end
        end
        // Status register writes by instruction
        if (exDone && exOp == `TSCP_OP_SRSET) begin
            next_s.intMask   = s.intMask | s.exInstr[3:0];
            next_s.debugMask = s.debugMask | s.exInstr[`TSCP_SR_DMASK_BIT];
        end
        if (exDone && exOp == `TSCP_OP_SRCLR) begin
            next_s.intMask   = s.intMask & ~s.exInstr[3:0];
            next_s.debugMask = s.debugMask & ~s.exInstr[`TSCP_SR_DMASK_BIT];
        end
        // Execute stage empties when done, refills from decode
        if (exDone) next_s.exV = 1'b0;
        if (adv && !takeDbg) begin
            next_s.exV     = 1'b1;
            next_s.exFirst = 1'b1;
            next_s.exInstr = s.decInstr;
            next_s.exPc    = s.decPc;
            next_s.mulCnt  = 4'(MUL_CYCLES - 1);
        end
        if (adv) next_s.decV = 1'b0;
        // Fetch: unless redirected or entering debug, take a word whenever decode will be free
        if (redirect) begin
            next_s.decV = 1'b0;
            next_s.pcF  = target;
        end else if (takeDbg) begin
            next_s.pcF            = `TSCP_DEBUG_VECTOR;
            next_s.retAddr        = s.decPc;
            next_s.savedIntMask   = s.intMask;
            next_s.savedDebugMask = s.debugMask;
            next_s.intMask        = '1;
            next_s.debugState     = 1'b1;
        end else if ((!s.decV || adv) && imemValid) begin
            next_s.decV     = 1'b1;
            next_s.decInstr = imemData;
            next_s.decPc    = s.pcF;
            next_s.pcF      = s.pcF + `TSCP_INST_STEP;
        end
        // Return from debug restores the saved masks
        if (redirect && exOp == `TSCP_OP_RETD) begin
            next_s.debugState = 1'b0;
            next_s.intMask    = s.savedIntMask;
            next_s.debugMask  = s.savedDebugMask;
        end
    end

    // State register; reset leaves every stage empty
    always_ff @(posedge core_clk) begin
        if (reset) begin
            s     <= '0;
            s.pcF <= `TSCP_RESET_ADDR;
        end else begin
            s <= next_s;
        end
    end

    assign imemReq     = s.imemReq;
    assign imemAddr    = s.pcF;
    assign dmemOut     = s.dmem;
    assign debugState  = s.debugState;
    assign intMask     = s.intMask;
    assign debugMask   = s.debugMask;
    assign retireValid = s.retireValid;
    assign retirePc    = s.retirePc;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_resetEmpty;
        @(posedge core_clk) $fell(reset) |-> !s.decV && !s.exV && s.pcF == `TSCP_RESET_ADDR;
    endproperty
    a_resetEmpty: assert property (p_resetEmpty) else $error("pipeline not empty after reset");

    property p_holdStage;
        @(posedge core_clk) disable iff (reset)
        s.exV && !exDone |=> s.exV && $stable(s.exPc) && $stable(s.decPc);
    endproperty
    a_holdStage: assert property (p_holdStage) else $error("stage moved during multi-cycle op");

    property p_mulLatency;
        @(posedge core_clk) disable iff (reset)
        s.exV && s.exFirst && exOp == `TSCP_OP_MUL |-> !exDone [*2] ##1 exDone;
    endproperty
    a_mulLatency: assert property (p_mulLatency) else $error("product latency wrong");

    property p_aluOneCycle;
        @(posedge core_clk) disable iff (reset)
        s.exV && exOp == `TSCP_OP_ADD && s.decV && !takeDbg
            |-> exDone ##1 (s.exV && s.exPc == $past(s.decPc));
    endproperty
    a_aluOneCycle: assert property (p_aluOneCycle) else $error("no back-to-back issue");

    property p_dbgMaskAll;
        @(posedge core_clk) disable iff (reset)
        $rose(s.debugState) |-> s.intMask == 4'hf && s.pcF == `TSCP_DEBUG_VECTOR;
    endproperty
    a_dbgMaskAll: assert property (p_dbgMaskAll) else $error("masks not set on debug entry");

    property p_dbgExit;
        @(posedge core_clk) disable iff (reset)
        $fell(s.debugState) |-> $past(exOp) == `TSCP_OP_RETD && $past(exDone);
    endproperty
    a_dbgExit: assert property (p_dbgExit) else $error("debug left without return");

    property p_dbgRefuse;
        @(posedge core_clk) disable iff (reset)
        s.debugMask && !s.debugState |=> !s.debugState;
    endproperty
    a_dbgRefuse: assert property (p_dbgRefuse) else $error("debug entered while masked");

    property p_maskClear;
        @(posedge core_clk) disable iff (reset)
        exDone && exOp == `TSCP_OP_SRCLR && !takeDbg
            |=> (s.intMask & $past(s.exInstr[3:0])) == 4'h0;
    endproperty
    a_maskClear: assert property (p_maskClear) else $error("mask bit not cleared");

    property p_byteSign;
        @(posedge core_clk) disable iff (reset)
        rfWrEn && exOp == `TSCP_OP_LOAD && s.exInstr[`TSCP_F_SIZE] == `TSCP_SZ_BYTE
            |-> rfWrData[31:8] == {24{s.exInstr[`TSCP_F_SIGN] & rfWrData[7]}};
    endproperty
    a_byteSign: assert property (p_byteSign) else $error("byte load extension wrong");

endmodule // tscp_pipeline
`default_nettype wire

// *** verif/tscp_mem_model.sv ***
// Instruction and data memory model for the pipeline's local bus
`timescale 1ns/1ps
`default_nettype none
module tscp_mem_model (
    // Clock
    input  wire logic                     core_clk,
    // Instruction side
    input  wire logic                     imemReq,
    input  wire logic [31:0]              imemAddr,
    output logic                          imemValid,
    output logic [31:0]                   imemData,
    // Data side
    input  wire tscp_pkg::tscp_dmem_req_t dmemOut,
    input  wire logic [1:0]               waitCycles,
    output logic                          dmemValid,
    output logic [31:0]                   dmemRdata
);
    import tscp_pkg::*;

    logic [31:0] prog [0:255];
    logic [31:0] data [0:63];
    logic [1:0]  waitCnt = 2'h0;
    logic [31:0] lastRd  = 32'h5a5a_a5a5;

    // Fetch answers at once; between requests the lines carry junk, not the last word
    assign imemValid = imemReq;
    assign imemData  = imemReq ? prog[imemAddr[9:2]] : ~imemAddr;

    // Data answers after waitCycles idle cycles; idle read lines show inverted data
    assign dmemValid = dmemOut.req && (waitCnt == waitCycles);
    assign dmemRdata = dmemValid ? data[dmemOut.addr[7:2]] : ~lastRd;

    // Plain always so the bench may preload the array; writes honour byte enables
    always @(posedge core_clk) begin
        if (!dmemOut.req || dmemValid) begin
            waitCnt <= 2'h0;
        end else begin
            waitCnt <= waitCnt + 2'h1;
        end
        if (dmemValid) begin
            lastRd <= dmemRdata;
            for (int b = 0; b < 4; b++) begin
                if (dmemOut.we && dmemOut.be[b]) begin
                    data[dmemOut.addr[7:2]][8*b +: 8] <= dmemOut.wdata[8*b +: 8];
                end
            end
        end
    end
endmodule // tscp_mem_model
`default_nettype wire

// *** verif/three_stage_cpu_pipeline_tb.sv ***
// Self-checking bench for the three-stage pipeline control
`timescale 1ns/1ps
`default_nettype none
module three_stage_cpu_pipeline_tb;
    import tscp_pkg::*;

    localparam int MULC = 3;
    // Straight program: load, dependent arithmetic, product, sub-word and double moves
    localparam logic [31:0] PROG [20] = '{
        32'h81f0_8000, 32'h6210_4085, 32'h1522_0000, 32'h6310_0003, 32'h7653_0000,
        32'h9015_8040, 32'h9016_8044, 32'h8710_2041, 32'h8810_0041, 32'h8910_6040,
        32'h8a10_4040, 32'h9017_8048, 32'h9018_804c, 32'h9019_8050, 32'h901a_8054,
        32'h9615_c058, 32'h8b10_c040, 32'h901c_8060, 32'h9012_0069, 32'ha010_004c};
    localparam int EIDX [10] = '{16, 17, 18, 19, 20, 21, 22, 23, 24, 26};
    localparam logic [31:0] EVAL [10] = '{
        32'h0000_810a, 32'h0001_831e, 32'hffff_ff81, 32'h0000_0081, 32'hffff_810a,
        32'h0000_810a, 32'h0000_810a, 32'h0001_831e, 32'h0001_831e, 32'h0000_8500};

    logic                    core_clk    = 1'b0;
    logic                    reset       = 1'b1;
    logic                    debugReqPin = 1'b0;
    logic [1:0]              waitCycles  = 2'h0;
    logic                    imemReq, imemValid, dmemValid;
    logic [31:0]             imemAddr, imemData, dmemRdata, retirePc;
    tscp_dmem_req_t          dmemOut;
    logic                    debugState, debugMask, retireValid;
    logic [3:0]              intMask;
    int                      errors, checksDone, cyc, n;
    logic [31:0]             retPc [$];
    int                      retCyc [$];

    always #20 core_clk = ~core_clk;

    tscp_pipeline #(.MUL_CYCLES(MULC)) u_dut (
        .core_clk(core_clk), .reset(reset), .imemReq(imemReq), .imemAddr(imemAddr),
        .imemValid(imemValid), .imemData(imemData), .dmemOut(dmemOut),
        .dmemValid(dmemValid), .dmemRdata(dmemRdata), .debugReqPin(debugReqPin),
        .debugState(debugState), .intMask(intMask), .debugMask(debugMask),
        .retireValid(retireValid), .retirePc(retirePc));

    tscp_mem_model u_mem (
        .core_clk(core_clk), .imemReq(imemReq), .imemAddr(imemAddr),
        .imemValid(imemValid), .imemData(imemData), .dmemOut(dmemOut),
        .waitCycles(waitCycles), .dmemValid(dmemValid), .dmemRdata(dmemRdata));

    // Retirement log; the gaps between entries show stalls and throughput
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (reset) begin
            retPc.delete();
            retCyc.delete();
        end else if (retireValid === 1'b1) begin
            retPc.push_back(retirePc);
            retCyc.push_back(cyc);
        end
    end

    task automatic step();
        @(posedge core_clk);
        #1;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("errors %0d checks %0d", errors, checksDone);
        if (errors == 0 && checksDone > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Reset, run the program with the given data wait, then judge memory and retirement
    task automatic run_prog(input logic [1:0] w);
        reset = 1'b1;
        waitCycles = w;
        for (int i = 0; i < 256; i++) u_mem.prog[i] = (i < 20) ? PROG[i] : 32'h0;
        for (int i = 0; i < 64; i++) u_mem.data[i] = 32'h0;
        // Monitor: unmask two levels, sub/and/or/xor chain stored to word 28, return
        u_mem.prog[64] = 32'hc000_0005;
        u_mem.prog[65] = 32'h2465_0000;
        u_mem.prog[66] = 32'h3449_0000;
        u_mem.prog[67] = 32'h4448_0000;
        u_mem.prog[68] = 32'h5445_0000;
        u_mem.prog[69] = 32'h9014_8070;
        u_mem.prog[70] = 32'hd000_0000;
        u_mem.prog[71] = 32'ha010_011c;
        repeat (12) step();
        chk({31'h0, imemReq}, 32'h0);
        chk(imemAddr, 32'h0);
        chk({30'h0, debugState, retireValid}, 32'h0);
        reset = 1'b0;
        for (n = 0; n < 400 && retPc.size() < 20; n++) step();
        for (int i = 0; i < 20; i++) chk(retPc[i], 32'(4 * i));
        chk(32'(retCyc[3] - retCyc[2]), 32'h1);
        chk(32'(retCyc[4] - retCyc[3]), 32'(MULC));
        for (int i = 0; i < 10; i++) chk(u_mem.data[EIDX[i]], EVAL[i]);
    endtask

    // Enter debug, unmask two levels from the monitor, leave by the return instruction
    task automatic debug_test();
        debugReqPin = 1'b1;
        for (n = 0; n < 50 && debugState !== 1'b1; n++) step();
        debugReqPin = 1'b0;
        chk({28'h0, intMask}, 32'hf);
        for (n = 0; n < 50 && intMask !== 4'ha; n++) step();
        chk({28'h0, intMask}, 32'ha);
        chk({31'h0, debugState}, 32'h1);
        for (n = 0; n < 50 && debugState !== 1'b0; n++) step();
        chk({31'h0, debugState}, 32'h0);
        chk(u_mem.data[28], 32'h0001_818b);
    endtask

    // Set the debug-entry mask from normal code, then request debug and expect refusal
    task automatic mask_test();
        int hits;
        hits = 0;
        u_mem.prog[19] = 32'hb000_0010;
        u_mem.prog[20] = 32'ha010_0050;
        for (n = 0; n < 50 && debugMask !== 1'b1; n++) step();
        chk({31'h0, debugMask}, 32'h1);
        debugReqPin = 1'b1;
        repeat (30) begin
            step();
            if (debugState !== 1'b0) hits++;
        end
        debugReqPin = 1'b0;
        chk(32'(hits), 32'h0);
    endtask

    initial begin
        run_prog(2'h0);
        run_prog(2'h2);
        debug_test();
        mask_test();
        end_sim();
    end

    // Whole run needs well under 2000 cycles
    initial begin
        #200000;
        errors++;
        end_sim();
    end
endmodule // three_stage_cpu_pipeline_tb
`default_nettype wire
